// ### rtl/lmcs_clock_share.sv
`timescale 1ns/1ps
module lmcs_clock_share
  import lmcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  lmcs_tick_if.src tk
);
  logic [9:0] cnt_q;
  logic [9:0] half_d;

  always_comb
  begin
    case (tk.freq_sel)
      2'b00: half_d = HALF_1M;
      2'b01: half_d = HALF_500K;
      2'b10: half_d = HALF_125K;
      default: half_d = HALF_32K;
    endcase
  end

  // Tick marks each half period of the shared clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (ce_i && !tk.run))
      cnt_q <= 10'h000;
    else if (ce_i)
      cnt_q <= (cnt_q + 10'h001 >= half_d) ? 10'h000 : cnt_q + 10'h001;
  end

  assign tk.tick = tk.run && (cnt_q + 10'h001 >= half_d);
endmodule

// ### rtl/lmcs_pkg.sv
package lmcs_pkg;
  // Register map (byte addresses on the internal register port)
  localparam logic [7:0] ADDR_MASK = 8'h07;
  localparam logic [7:0] ADDR_FRAME = 8'h08;
  localparam logic [7:0] ADDR_SHUTDOWN_TEST = 8'h09;
  localparam logic [7:0] ADDR_WATCHDOG = 8'h0A;
  localparam logic [7:0] ADDR_CLOCK_SHARE = 8'h0B;
  localparam logic [7:0] ADDR_CAUSE = 8'h0E;
  localparam logic [7:0] ADDR_SCAN_LIMIT = 8'h04;
  // Reset values
  localparam logic [7:0] RST_SHUTDOWN_TEST = 8'h02;
  localparam logic [7:0] RST_WATCHDOG = 8'hFF;
  localparam logic [7:0] RST_CLOCK_SHARE = 8'h00;
  localparam logic [7:0] RST_CAUSE = 8'h20;
  localparam logic [7:0] RST_MASK = 8'h20;
  localparam logic [5:0] RST_FRAME = 6'h3F;
  localparam logic [3:0] RST_SCAN_LIMIT = 4'hB;
  // Field positions
  localparam int SHDN_POWER_BIT = 0;
  localparam int SHDN_RESTART_BIT = 1;
  localparam int SHDN_ON_WRITE_BIT = 2;
  localparam int SHDN_ON_START_BIT = 3;
  localparam int SHDN_EVERY_BIT = 4;
  localparam int WD_ENABLE_BIT = 0;
  localparam int WD_PERIOD_LSB = 1;
  localparam int CS_ACCEPT_BIT = 0;
  localparam int CS_DRIVE_BIT = 1;
  localparam int CS_FREQ_LSB = 2;
  localparam int CAUSE_FRAME = 7;
  localparam int CAUSE_WATCHDOG = 6;
  localparam int CAUSE_POR = 5;
  localparam int CAUSE_OVERTEMP = 4;
  localparam int CAUSE_LOW_SUPPLY = 3;
  localparam int CAUSE_OPEN = 2;
  localparam int CAUSE_SHORT = 1;
  localparam int CAUSE_MOVIE = 0;
  // Timing: system clock 20 MHz
  localparam int CLK_HZ = 20000000;
  localparam int WD_UNIT_US = 256;
  localparam int WD_UNIT_CYC = WD_UNIT_US * (CLK_HZ / 1000000);
  localparam logic [12:0] WD_UNIT_CYC_M1 = 13'(WD_UNIT_CYC - 1);
  // Clock-share half periods in system cycles (round down)
  localparam int FREQ_1M_HZ = 1000000;
  localparam int FREQ_500K_HZ = 500000;
  localparam int FREQ_125K_HZ = 125000;
  localparam int FREQ_32K_HZ = 32000;
  localparam logic [9:0] HALF_1M = 10'(CLK_HZ / (2 * FREQ_1M_HZ));
  localparam logic [9:0] HALF_500K = 10'(CLK_HZ / (2 * FREQ_500K_HZ));
  localparam logic [9:0] HALF_125K = 10'(CLK_HZ / (2 * FREQ_125K_HZ));
  localparam logic [9:0] HALF_32K = 10'(CLK_HZ / (2 * FREQ_32K_HZ));
  typedef enum logic [1:0]
  {
    LMCS_RUN = 2'b00,
    LMCS_SHUTDOWN = 2'b01,
    LMCS_RESTART = 2'b10
  } lmcs_ctl_e;
endpackage

// ### rtl/lmcs_tick_if.sv
`timescale 1ns/1ps
interface lmcs_tick_if;
  logic [1:0] freq_sel;
  logic run;
  logic tick;
  modport src (input freq_sel, input run, output tick);
  modport dst (output freq_sel, output run, input tick);
endinterface

// ### rtl/lmcs_top.sv
`timescale 1ns/1ps
// Behaviour
// - power_down_n low halts state and LEDs
// - restart bit low resets control machine
// - shutdown/test register resets to 0x02
// - check_on_write starts test after update
// - check_on_display_start tests on display start
// - check_every_location selects full test coverage
// - test covers only scan-limited segments
// - watchdog resets stuck bus interface
// - timeout is (n+1) times 256 us
// - bus_watchdog_enable switches monitoring
// - watchdog register resets to 0xFF
// - frequency select picks shared clock rate
// - drive_clock_pin drives clock on pin
// - accept_external_clock takes clock from pin
// - cause register read-only, read restores it to 0x20
// - cause bit order frame down to movie
// - cause register resets to 0x20
// - IRQ gated by matching mask bit
// - frame flag after final trigger frame
module lmcs_top
  import lmcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic show_picture_i,
  input wire logic play_animation_i,
  input wire logic frame_shown_i,
  input wire logic [5:0] frame_index_i,
  input wire logic last_loop_i,
  input wire logic overtemp_i,
  input wire logic low_supply_i,
  input wire logic open_error_i,
  input wire logic short_error_i,
  input wire logic animation_done_i,
  input wire logic test_busy_i,
  input wire logic sda_i,
  input wire logic clock_share_pin_i,
  output logic clock_share_pin_o,
  output logic clock_share_pin_oe_o,
  output logic irq_n_o,
  output logic leds_enable_o,
  output logic ctl_reset_o,
  output logic ctl_run_o,
  output logic bus_reset_o,
  output logic test_start_o,
  output logic test_every_location_o,
  output logic [3:0] test_segments_o,
  output logic ext_clock_select_o,
  output logic osc_enable_o,
  output logic ext_clock_edge_o
);
  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  logic [7:0] shutdown_test_control_q;
  logic [7:0] bus_watchdog_config_q;
  logic [7:0] clock_share_config_q;
  logic [7:0] interrupt_cause_q;
  logic [7:0] interrupt_cause_d;
  logic [7:0] mask_q;
  logic [5:0] trigger_frame_index_q;
  logic [3:0] scan_limit_q;
  lmcs_ctl_e ctl_q;
  logic [7:0] events;
  logic sda_s1_q;
  logic sda_s2_q;
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_s3_q;
  logic show_q;
  logic play_q;
  logic wd_fire;
  logic share_clk_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  // shutdown reset value
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      shutdown_test_control_q <= RST_SHUTDOWN_TEST;
    else if (ce_i && reg_wr_i && hit(reg_addr_i, ADDR_SHUTDOWN_TEST))
      shutdown_test_control_q <= {3'h0, reg_wdata_i[4:0]};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bus_watchdog_config_q <= RST_WATCHDOG;
    else if (ce_i && reg_wr_i && hit(reg_addr_i, ADDR_WATCHDOG))
      bus_watchdog_config_q <= {1'b1, reg_wdata_i[6:0]};
  end

  // both clock directions set is a host fault; input takes priority below
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      clock_share_config_q <= RST_CLOCK_SHARE;
    else if (ce_i && reg_wr_i && hit(reg_addr_i, ADDR_CLOCK_SHARE))
      clock_share_config_q <= {4'h0, reg_wdata_i[3:0]};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mask_q <= RST_MASK;
      trigger_frame_index_q <= RST_FRAME;
      scan_limit_q <= RST_SCAN_LIMIT;
    end
    else if (ce_i && reg_wr_i)
    begin
      if (hit(reg_addr_i, ADDR_MASK))
        mask_q <= reg_wdata_i;
      if (hit(reg_addr_i, ADDR_FRAME))
        trigger_frame_index_q <= reg_wdata_i[5:0];
      if (hit(reg_addr_i, ADDR_SCAN_LIMIT))
        scan_limit_q <= reg_wdata_i[3:0];
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      reg_rdata_o <= 8'h00;
    else if (ce_i && reg_rd_i)
    begin
      case (reg_addr_i)
        ADDR_MASK: reg_rdata_o <= mask_q;
        ADDR_FRAME: reg_rdata_o <= {2'h0, trigger_frame_index_q};
        ADDR_SCAN_LIMIT: reg_rdata_o <= {4'h0, scan_limit_q};
        ADDR_SHUTDOWN_TEST: reg_rdata_o <= shutdown_test_control_q;
        ADDR_WATCHDOG: reg_rdata_o <= bus_watchdog_config_q;
        ADDR_CLOCK_SHARE: reg_rdata_o <= clock_share_config_q;
        ADDR_CAUSE: reg_rdata_o <= interrupt_cause_q;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Control state machine
  // ------------------------------------------------------------
  // shutdown halts
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctl_q <= LMCS_SHUTDOWN;
    else if (ce_i)
    begin
      case (ctl_q)
        LMCS_RUN:
          if (!shutdown_test_control_q[SHDN_RESTART_BIT])
            ctl_q <= LMCS_RESTART;
          else if (!shutdown_test_control_q[SHDN_POWER_BIT])
            ctl_q <= LMCS_SHUTDOWN;
        LMCS_SHUTDOWN:
          if (!shutdown_test_control_q[SHDN_RESTART_BIT])
            ctl_q <= LMCS_RESTART;
          else if (shutdown_test_control_q[SHDN_POWER_BIT])
            ctl_q <= LMCS_RUN;
        LMCS_RESTART:
          if (shutdown_test_control_q[SHDN_RESTART_BIT])
            ctl_q <= shutdown_test_control_q[SHDN_POWER_BIT] ? LMCS_RUN : LMCS_SHUTDOWN;
        default: ctl_q <= LMCS_SHUTDOWN;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      leds_enable_o <= 1'b0;
      ctl_run_o <= 1'b0;
      ctl_reset_o <= 1'b0;
    end
    else if (ce_i)
    begin
      leds_enable_o <= (ctl_q == LMCS_RUN);
      ctl_run_o <= (ctl_q == LMCS_RUN);
      ctl_reset_o <= (ctl_q == LMCS_RESTART);
    end
  end

  // ------------------------------------------------------------
  // Open/short test launch
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      show_q <= 1'b0;
      play_q <= 1'b0;
      test_start_o <= 1'b0;
      test_every_location_o <= 1'b0;
      test_segments_o <= RST_SCAN_LIMIT;
    end
    else if (ce_i)
    begin
      show_q <= show_picture_i;
      play_q <= play_animation_i;
      test_start_o <= (reg_wr_i && hit(reg_addr_i, ADDR_SHUTDOWN_TEST) &&
                       reg_wdata_i[SHDN_ON_WRITE_BIT]) ||
                      (shutdown_test_control_q[SHDN_ON_START_BIT] &&
                       ((show_picture_i && !show_q) || (play_animation_i && !play_q)));
      test_every_location_o <= shutdown_test_control_q[SHDN_EVERY_BIT];
      test_segments_o <= scan_limit_q;
    end
  end

  // ------------------------------------------------------------
  // Bus watchdog
  // ------------------------------------------------------------
  // Data line comes from the pin, so it is synchronised first
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end
    else if (ce_i)
    begin
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
    end
  end

  lmcs_watchdog u_watchdog (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .enable_i(bus_watchdog_config_q[WD_ENABLE_BIT]),
    .period_i({1'b0, bus_watchdog_config_q[WD_PERIOD_LSB +: 6]}),
    .stuck_i(!sda_s2_q),
    .fire_o(wd_fire)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bus_reset_o <= 1'b0;
    else if (ce_i)
      bus_reset_o <= wd_fire;
  end

  // ------------------------------------------------------------
  // Clock sharing
  // ------------------------------------------------------------
  lmcs_tick_if tk ();

  assign tk.freq_sel = clock_share_config_q[CS_FREQ_LSB +: 2];
  assign tk.run = clock_share_config_q[CS_DRIVE_BIT] && !clock_share_config_q[CS_ACCEPT_BIT];

  lmcs_clock_share u_clock_share (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .tk(tk)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      share_clk_q <= 1'b0;
      clock_share_pin_o <= 1'b0;
      clock_share_pin_oe_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!tk.run)
        share_clk_q <= 1'b0;
      else if (tk.tick)
        share_clk_q <= !share_clk_q;
      clock_share_pin_o <= share_clk_q;
      clock_share_pin_oe_o <= tk.run;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
      ext_clock_select_o <= 1'b0;
      osc_enable_o <= 1'b1;
      ext_clock_edge_o <= 1'b0;
    end
    else if (ce_i)
    begin
      pin_s1_q <= clock_share_pin_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      ext_clock_select_o <= clock_share_config_q[CS_ACCEPT_BIT];
      osc_enable_o <= !clock_share_config_q[CS_ACCEPT_BIT];
      ext_clock_edge_o <= clock_share_config_q[CS_ACCEPT_BIT] && pin_s2_q && !pin_s3_q;
    end
  end

  // ------------------------------------------------------------
  // Interrupt cause and IRQ pin
  // ------------------------------------------------------------
  // cause bit order
  always_comb
  begin
    events = 8'h00;
    events[CAUSE_FRAME] = frame_shown_i && last_loop_i &&
                          (frame_index_i == trigger_frame_index_q);
    events[CAUSE_WATCHDOG] = wd_fire;
    events[CAUSE_POR] = 1'b0;
    events[CAUSE_OVERTEMP] = overtemp_i;
    events[CAUSE_LOW_SUPPLY] = low_supply_i;
    events[CAUSE_OPEN] = open_error_i;
    events[CAUSE_SHORT] = short_error_i;
    events[CAUSE_MOVIE] = animation_done_i;
  end

  // read restores default; new events win
  always_comb
  begin
    interrupt_cause_d = interrupt_cause_q;
    if (reg_rd_i && hit(reg_addr_i, ADDR_CAUSE))
      interrupt_cause_d = RST_CAUSE;
    interrupt_cause_d = interrupt_cause_d | events;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      interrupt_cause_q <= RST_CAUSE;
    else if (ce_i)
      interrupt_cause_q <= interrupt_cause_d;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_n_o <= 1'b1;
    else if (ce_i)
      irq_n_o <= ~|(interrupt_cause_d & mask_q);
  end

  // Status of a running test is not mirrored here; test_busy_i is reserved
  logic unused_busy;
  assign unused_busy = test_busy_i;
endmodule

// ### rtl/lmcs_watchdog.sv
`timescale 1ns/1ps
module lmcs_watchdog
  import lmcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic enable_i,
  input wire logic [6:0] period_i,
  input wire logic stuck_i,
  output logic fire_o
);
  logic [12:0] unit_q;
  logic [6:0] units_q;

  // Counts while the bus stays stuck; any release restarts the window
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      unit_q <= 13'h0000;
      units_q <= 7'h00;
      fire_o <= 1'b0;
    end
    else if (ce_i)
    begin
      fire_o <= 1'b0;
      if (!enable_i || !stuck_i)
      begin
        unit_q <= 13'h0000;
        units_q <= 7'h00;
      end
      else if (unit_q == WD_UNIT_CYC_M1)
      begin
        unit_q <= 13'h0000;
        if (units_q == period_i)
        begin
          units_q <= 7'h00;
          fire_o <= 1'b1;
        end
        else
          units_q <= units_q + 7'h01;
      end
      else
        unit_q <= unit_q + 13'h0001;
    end
  end
endmodule

// ### sim/lmcs_host_model.sv
`timescale 1ns/1ps
module lmcs_host_model
(
  input wire logic hold_low_i,
  input wire logic ext_run_i,
  output logic sda_o,
  output logic sync_o
);
  assign sda_o = hold_low_i ? 1'b0 : 1'b1;
  // pulls the data line low only when asked; drives it high otherwise
  // Clock stands still between bursts; phase offset keeps edges off clk
  initial
  begin
    sync_o = 1'b0;
    #7;
    forever
    begin
      #200;
      sync_o = ext_run_i ? ~sync_o : 1'b0;
    end
  end
endmodule

// ### sim/lmcs_top_sva.sv
`timescale 1ns/1ps
module lmcs_top_sva
  import lmcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic sda_i,
  input wire logic clock_share_pin_o,
  input wire logic clock_share_pin_oe_o,
  input wire logic leds_enable_o,
  input wire logic ctl_reset_o,
  input wire logic bus_reset_o,
  input wire logic test_start_o,
  input wire logic ext_clock_select_o,
  input wire logic osc_enable_o,
  input wire logic ext_clock_edge_o
);
  logic [15:0] low_q;
  logic [9:0] still_q;
  // Raw low time bounds what the synchronised counter can have seen
  always_ff @(posedge clk_i)
  begin
    if (rst_i || sda_i)
      low_q <= 16'h0000;
    else if (low_q != 16'hFFFF)
      low_q <= low_q + 16'h0001;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i || $changed(clock_share_pin_o))
      still_q <= 10'h000;
    else if (still_q != 10'h3FF)
      still_q <= still_q + 10'h001;
  end
  // ----------------------------------------
  // Access sequences
  // ----------------------------------------
  sequence wr_shdn;
    ce_i && reg_wr_i && reg_addr_i == ADDR_SHUTDOWN_TEST;
  endsequence
  sequence rd_at(logic [7:0] a);
    ce_i && reg_rd_i && reg_addr_i == a;
  endsequence
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  test_start_a: assert property (wr_shdn ##0 reg_wdata_i[2] |=> test_start_o)
    else $error("no test start after write");
  ctl_reset_a: assert property (wr_shdn ##0 !reg_wdata_i[1] |-> ##[1:3] ctl_reset_o)
    else $error("restart write did not reset control");
  leds_off_a: assert property (wr_shdn ##0 !reg_wdata_i[0] |-> ##[1:3] !leds_enable_o)
    else $error("shutdown write left outputs on");
  shdn_spare_a: assert property (rd_at(ADDR_SHUTDOWN_TEST) |=> reg_rdata_o[7:5] == 3'h0)
    else $error("spare control bits not zero");
  wd_spare_a: assert property (rd_at(ADDR_WATCHDOG) |=> reg_rdata_o[7])
    else $error("spare watchdog bit not one");
  cause_por_a: assert property (rd_at(ADDR_CAUSE) |=> reg_rdata_o[5])
    else $error("cause read lost power-on bit");
  wd_window_a: assert property (bus_reset_o |-> low_q >= 16'h1400)
    else $error("bus reset before shortest window");
  wd_pulse_a: assert property (bus_reset_o |=> !bus_reset_o)
    else $error("bus reset longer than one cycle");
  drive_dir_a: assert property (clock_share_pin_oe_o |-> !ext_clock_select_o)
    else $error("pin driven while accepting clock");
  osc_off_a: assert property (osc_enable_o != ext_clock_select_o)
    else $error("oscillator and external clock disagree");
  ext_edge_a: assert property (ext_clock_edge_o |-> ext_clock_select_o || $past(ext_clock_select_o))
    else $error("external edge while not accepting");
  share_half_a: assert property (clock_share_pin_oe_o && $past(clock_share_pin_oe_o)
    && $changed(clock_share_pin_o) |-> still_q >= 10'h009)
    else $error("shared clock half period too short");
endmodule

bind lmcs_top lmcs_top_sva u_sva (.*);

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import lmcs_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic show_picture_i = 1'b0;
  logic play_animation_i = 1'b0;
  logic [7:0] ev = 8'h00;
  logic frame_shown_i, overtemp_i, low_supply_i, open_error_i, short_error_i, animation_done_i;
  logic [5:0] frame_index_i = 6'h05;
  logic last_loop_i = 1'b1;
  logic test_busy_i = 1'b0;
  logic sda_i, clock_share_pin_i, sync, hold = 1'b0, ext_run = 1'b0;
  logic clock_share_pin_o, clock_share_pin_oe_o, irq_n_o, leds_enable_o, ctl_reset_o, ctl_run_o;
  logic bus_reset_o, test_start_o, test_every_location_o, ext_clock_select_o, osc_enable_o;
  logic ext_clock_edge_o;
  logic [3:0] test_segments_o;
  logic [7:0] v;
  int miscompares = 0;
  int tests_run = 0;
  int n_start = 0, n_bus = 0, n_edge = 0, s, c;
  localparam logic [7:0] RA [4] = '{ADDR_SHUTDOWN_TEST, ADDR_WATCHDOG, ADDR_CLOCK_SHARE, ADDR_CAUSE};
  localparam logic [7:0] RV [4] = '{8'h02, 8'hFF, 8'h00, 8'h20};
  localparam int EB [6] = '{0, 1, 2, 3, 4, 7};
  localparam int HP [4] = '{10, 20, 80, 312};
  assign {overtemp_i, low_supply_i, open_error_i, short_error_i, animation_done_i} = ev[4:0];
  assign frame_shown_i = ev[7];
  assign clock_share_pin_i = clock_share_pin_oe_o ? clock_share_pin_o : sync;
  lmcs_top u_dut (.*);
  lmcs_host_model u_host (.hold_low_i(hold), .ext_run_i(ext_run), .sda_o(sda_i), .sync_o(sync));
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    n_start += int'(test_start_o === 1'b1);
    n_bus += int'(bus_reset_o === 1'b1);
    n_edge += int'(ext_clock_edge_o === 1'b1);
  end
  // ----------------------------------------
  // Access and check tasks
  // ----------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    tick();
    reg_wr_i = 1'b0;
    tick();
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    tick();
    reg_rd_i = 1'b0;
    tick();
    d = reg_rdata_o;
  endtask
  task automatic half_len(output int n);
    logic p;
    n = 0;
    p = clock_share_pin_o;
    while (clock_share_pin_o === p && n < 700)
    begin
      tick();
      n++;
    end
  endtask
  task automatic final_report;
    if (miscompares == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    tick(6);
    rst_i = 1'b0;
    tick(2);
    chk(irq_n_o, 1'b0);
    chk(test_segments_o, 4'hB);
    foreach (RA[i])
    begin
      rd_reg(RA[i], v);
      chk(v, RV[i]);
    end
    wr_reg(ADDR_CAUSE, 8'hFF);
    rd_reg(ADDR_CAUSE, v);
    chk(v, 8'h20);
    wr_reg(ADDR_SCAN_LIMIT, 8'h05);
    tick(2);
    chk(test_segments_o, 4'h5);
    s = n_start;
    wr_reg(ADDR_SHUTDOWN_TEST, 8'h07);
    tick(3);
    chk(16'(n_start - s), 16'h0001);
    chk(leds_enable_o, 1'b1);
    chk(ctl_run_o, 1'b1);
    chk(ctl_reset_o, 1'b0);
    wr_reg(ADDR_SHUTDOWN_TEST, 8'h10);
    tick(3);
    chk(16'(n_start - s), 16'h0001);
    chk(test_every_location_o, 1'b1);
    chk(leds_enable_o, 1'b0);
    chk(ctl_run_o, 1'b0);
    chk(ctl_reset_o, 1'b1);
    wr_reg(ADDR_SHUTDOWN_TEST, 8'h0B);
    show_picture_i = 1'b1;
    tick(3);
    show_picture_i = 1'b0;
    play_animation_i = 1'b1;
    tick(3);
    play_animation_i = 1'b0;
    chk(16'(n_start - s), 16'h0003);
    chk(test_every_location_o, 1'b0);
    wr_reg(ADDR_FRAME, 8'h05);
    foreach (EB[i])
    begin
      wr_reg(ADDR_MASK, 8'h00);
      ev[EB[i]] = 1'b1;
      tick();
      ev[EB[i]] = 1'b0;
      tick(2);
      chk(irq_n_o, 1'b1);
      wr_reg(ADDR_MASK, 8'h01 << EB[i]);
      tick(2);
      chk(irq_n_o, 1'b0);
      rd_reg(ADDR_CAUSE, v);
      chk(v, 8'h20 | (8'h01 << EB[i]));
      chk(irq_n_o, 1'b1);
    end
    // Trigger frame outside the final loop must not flag
    wr_reg(ADDR_MASK, 8'h80);
    last_loop_i = 1'b0;
    ev[7] = 1'b1;
    tick();
    ev[7] = 1'b0;
    last_loop_i = 1'b1;
    tick(2);
    chk(irq_n_o, 1'b1);
    rd_reg(ADDR_CAUSE, v);
    chk(v, 8'h20);
    wr_reg(ADDR_MASK, 8'h40);
    for (int n = 0; n < 2; n++)
    begin
      wr_reg(ADDR_WATCHDOG, 8'(n * 2 + 1));
      s = n_bus;
      c = 0;
      hold = 1'b1;
      while (n_bus == s && c < 20000)
      begin
        tick();
        c++;
      end
      hold = 1'b0;
      chk(c >= (n + 1) * 5120 && c <= (n + 1) * 5120 + 6, 1'b1);
      tick(2);
      chk(irq_n_o, 1'b0);
      rd_reg(ADDR_CAUSE, v);
      chk(v, 8'h60);
    end
    wr_reg(ADDR_WATCHDOG, 8'h00);
    s = n_bus;
    hold = 1'b1;
    tick(6000);
    hold = 1'b0;
    chk(16'(n_bus - s), 16'h0000);
    foreach (HP[k])
    begin
      wr_reg(ADDR_CLOCK_SHARE, 8'h00);
      tick(2);
      wr_reg(ADDR_CLOCK_SHARE, 8'(k * 4 + 2));
      tick(2);
      chk(clock_share_pin_oe_o, 1'b1);
      half_len(c);
      half_len(c);
      chk(16'(c), 16'(HP[k]));
    end
    wr_reg(ADDR_CLOCK_SHARE, 8'h01);
    tick(3);
    chk(clock_share_pin_oe_o, 1'b0);
    chk(osc_enable_o, 1'b0);
    chk(ext_clock_select_o, 1'b1);
    s = n_edge;
    ext_run = 1'b1;
    tick(80);
    ext_run = 1'b0;
    chk(n_edge - s >= 9 && n_edge - s <= 11, 1'b1);
    final_report();
  end
  initial
  begin
    #3000000;
    miscompares++;
    final_report();
  end
endmodule
